// ---- logic/aux_lock_pkg.sv ----
// constants for the auxiliary-path lock indicator and its register file
// assumes a 32-bit apb slave with one register per aligned word
package aux_lock_pkg;
    // printed register numbers are indices; byte address is four times
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h08;
    localparam logic [7:0]  IDX_OP_STATUS   = 8'h09;
    localparam logic [7:0]  IDX_PHASE_CFG_A = 8'h49;
    localparam logic [7:0]  IDX_PHASE_CFG_B = 8'h4A;
    localparam logic [7:0]  IDX_FREQ_CFG    = 8'h4B;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'h4C;
    localparam int          ADDR_W          = 12;
    // field positions
    localparam int          BIT_LOCK        = 6;
    localparam int          BIT_MAIN_WARN   = 5;
    localparam int          BIT_AUX_WARN    = 4;
    localparam int          BIT_FINE_EN     = 7;
    localparam int          BIT_NOACT_EN    = 6;
    localparam int          BIT_COARSE_EN   = 7;
    localparam int          BIT_FREQ_EN     = 7;
    localparam int          BIT_LOCK_CHG    = 6;
    // reset values
    localparam logic [7:0]  RST_OP_STATUS   = 8'h41;
    localparam logic [7:0]  RST_CFG_A       = 8'hC0;
    localparam logic [7:0]  RST_CFG_B       = 8'h80;
    localparam logic [7:0]  RST_FREQ_CFG    = 8'h80;
    localparam logic [7:0]  RST_IRQ_MASK    = 8'h00;
    localparam logic [2:0]  RST_MAIN_STATE  = 3'h1;
endpackage

// ---- logic/lock_if.sv ----
// detector flags, enables and lock result between register file and detector
// assumes all members live on the single system clock
interface lock_if;
    logic fine_loss;
    logic coarse_loss;
    logic no_activity;
    logic freq_limit;
    logic en_fine;
    logic en_coarse;
    logic en_noact;
    logic en_freq;
    logic locked;
    logic lock_changed;
    modport det (input  fine_loss, coarse_loss, no_activity, freq_limit,
                 input  en_fine, en_coarse, en_noact, en_freq,
                 output locked, lock_changed);
    modport ctl (output fine_loss, coarse_loss, no_activity, freq_limit,
                 output en_fine, en_coarse, en_noact, en_freq,
                 input  locked, lock_changed);
endinterface

// ---- logic/aux_lock_detect.sv ----
// combines the fine and coarse phase-loss, no-activity and frequency-limit detectors into the auxiliary lock bit
// assumes detector flags are synchronous to clk
module aux_lock_detect
    import aux_lock_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // detector side
    lock_if.det       lk
);
    logic coarse_hold_q;
    logic coarse_hold_d;
    logic loss_d;
    logic locked_q;
    logic changed_q;

    always_comb begin
        coarse_hold_d = lk.en_coarse                     // RULE3
                      & (coarse_hold_q | lk.coarse_loss);
        loss_d = (lk.en_fine & lk.fine_loss)             // RULE2
               | (lk.en_noact & lk.no_activity)          // RULE4
               | (lk.en_freq & lk.freq_limit)            // RULE7
               | coarse_hold_d;                          // RULE5
    end

    // coarse loss held until its enable is cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            coarse_hold_q <= 1'b0;
        end else begin
            coarse_hold_q <= coarse_hold_d; // RULE5
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            locked_q  <= RST_OP_STATUS[BIT_LOCK];
            changed_q <= 1'b0;
        end else begin
            locked_q  <= ~loss_d;                // RULE1
            changed_q <= (~loss_d) != locked_q;
        end
    end

    assign lk.locked       = locked_q;
    assign lk.lock_changed = changed_q;

    a_fine_loss: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        lk.en_fine && lk.fine_loss |=> !locked_q)
        else $error("fine loss did not clear lock");
    a_noact_loss: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        lk.en_noact && lk.no_activity |=> !locked_q)
        else $error("no activity did not clear lock");
    a_freq_loss: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        lk.en_freq && lk.freq_limit |=> !locked_q)
        else $error("frequency limit did not clear lock");
    a_coarse_latch: assert property (@(posedge clk) // RULE5
        disable iff (!rst_n)
        lk.en_coarse && lk.coarse_loss ##1 lk.en_coarse[*2] |=> !locked_q)
        else $error("coarse loss not held while enabled");
    a_clean_lock: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        !lk.en_coarse && !(lk.en_fine && lk.fine_loss)
        && !(lk.en_noact && lk.no_activity)
        && !(lk.en_freq && lk.freq_limit) |=> locked_q)
        else $error("lock low with no enabled loss");
    a_coarse_release: assert property (@(posedge clk) // RULE7
        disable iff (!rst_n)
        !lk.en_coarse |=> !coarse_hold_q)
        else $error("coarse hold not released");

    c_coarse_held: cover property (@(posedge clk) disable iff (!rst_n)
        lk.en_coarse && lk.coarse_loss ##1 !lk.coarse_loss ##1 !locked_q);
    c_relock: cover property (@(posedge clk) disable iff (!rst_n)
        !locked_q ##1 locked_q);
endmodule

// ---- logic/aux_lock_top.sv ----
// apb register file and interrupt around the auxiliary lock detector
// assumes detector flags and main-path status come from logic on REF_CLK
//
// Behaviour
// RULE1: status register bit 6 reads 1 when the auxiliary path is locked.
// RULE2: the fine detector counts only while register 73 bit 7 is set.
// RULE3: the coarse detector counts only while register 74 bit 7 is set.
// RULE4: no input activity counts as loss when register 73 bit 6 is set.
// RULE5: a coarse loss holds the lock bit at 0 until the detector is disabled.
// RULE6: software disables the coarse detector, reads lock, then re-enables.
// RULE7: enabled frequency limits are loss; coarse disable frees its hold.
//
// Implementation choice: the APB slave port.
module aux_lock_top
    import aux_lock_pkg::*;
(
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // detector flags from the auxiliary loop
    input  wire logic              FINE_PHASE_LOSS,
    input  wire logic              COARSE_PHASE_LOSS,
    input  wire logic              INPUT_NO_ACTIVITY,
    input  wire logic              FREQ_LIMIT_HIT,
    // main-path status and auxiliary-path warning shown in the same register
    input  wire logic [2:0]        MAIN_PLL_STATE,
    input  wire logic              MAIN_PLL_FREQ_WARNING,
    input  wire logic              AUX_PLL_FREQ_WARNING,
    // interrupt
    output logic                   IRQ
);
    logic [7:0]  cfg_a_q;
    logic [7:0]  cfg_b_q;
    logic [7:0]  freq_cfg_q;
    logic [7:0]  irq_mask_q;
    logic [7:0]  irq_stat_q;
    logic [7:0]  op_status;
    logic [7:0]  rd_byte;
    logic        hit;
    logic        access;
    logic        wr_en;
    logic [7:0]  idx;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        irq_q;

    lock_if lk ();

    aux_lock_detect u_detect (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .lk    (lk)
    );

    assign lk.fine_loss   = FINE_PHASE_LOSS;
    assign lk.coarse_loss = COARSE_PHASE_LOSS;
    assign lk.no_activity = INPUT_NO_ACTIVITY;
    assign lk.freq_limit  = FREQ_LIMIT_HIT;
    assign lk.en_fine     = cfg_a_q[BIT_FINE_EN];    // RULE2
    assign lk.en_noact    = cfg_a_q[BIT_NOACT_EN];   // RULE4
    assign lk.en_coarse   = cfg_b_q[BIT_COARSE_EN];  // RULE3
    assign lk.en_freq     = freq_cfg_q[BIT_FREQ_EN]; // RULE7

    // word index from byte address; low two bits ignored
    assign idx    = PADDR[9:2];
    assign access = PSEL & PENABLE;
    assign wr_en  = access & pready_q & PWRITE & hit;

    always_comb begin
        op_status            = 8'h00;
        op_status[BIT_LOCK]  = lk.locked; // RULE1
        op_status[BIT_MAIN_WARN] = MAIN_PLL_FREQ_WARNING;
        op_status[BIT_AUX_WARN]  = AUX_PLL_FREQ_WARNING;
        op_status[2:0]       = MAIN_PLL_STATE;
    end

    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        if (PADDR[ADDR_W-1:10] != '0) begin
            hit = 1'b0;
        end else begin
            unique case (idx)
                IDX_IRQ_STATUS:  rd_byte = irq_stat_q;
                IDX_OP_STATUS:   rd_byte = op_status;
                IDX_PHASE_CFG_A: rd_byte = cfg_a_q;
                IDX_PHASE_CFG_B: rd_byte = cfg_b_q;
                IDX_FREQ_CFG:    rd_byte = freq_cfg_q;
                IDX_IRQ_MASK:    rd_byte = irq_mask_q;
                default:         hit = 1'b0;
            endcase
        end
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pready_q  <= 1'b1;
            prdata_q  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= ~hit;
        end else begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // enable registers; status register is read-only
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cfg_a_q    <= RST_CFG_A;
            cfg_b_q    <= RST_CFG_B;
            freq_cfg_q <= RST_FREQ_CFG;
            irq_mask_q <= RST_IRQ_MASK;
        end else if (wr_en) begin
            if (idx == IDX_PHASE_CFG_A) begin
                cfg_a_q <= PWDATA[7:0];
            end
            if (idx == IDX_PHASE_CFG_B) begin
                cfg_b_q <= PWDATA[7:0]; // RULE6
            end
            if (idx == IDX_FREQ_CFG) begin
                freq_cfg_q <= PWDATA[7:0];
            end
            if (idx == IDX_IRQ_MASK) begin
                irq_mask_q <= PWDATA[7:0];
            end
        end
    end

    // lock-change status: write one to clear, a new change wins
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_stat_q <= 8'h00;
        end else begin
            if (wr_en && idx == IDX_IRQ_STATUS && PWDATA[BIT_LOCK_CHG]) begin
                irq_stat_q[BIT_LOCK_CHG] <= 1'b0;
            end
            if (lk.lock_changed) begin
                irq_stat_q[BIT_LOCK_CHG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign IRQ     = irq_q;

    // register bus
    a_status_lock: assert property (@(posedge REF_CLK) // RULE1
        disable iff (!RST_N)
        access && !pready_q && !PWRITE && idx == IDX_OP_STATUS
        && PADDR[ADDR_W-1:10] == '0 |=> PRDATA[BIT_LOCK] == $past(lk.locked))
        else $error("status read does not show lock bit");
    a_ready_one: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not a single pulse after one wait");
    a_ready_idle: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        !PSEL |=> !PREADY)
        else $error("ready without a selected transfer");
    a_resp_idle: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
        else $error("read data or error outside ready cycle");
    a_err_unmapped: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        access && !pready_q && !hit |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        access && !pready_q && hit |=> !PSLVERR)
        else $error("error raised on mapped register");

    // write path
    a_cfg_write: assert property (@(posedge REF_CLK) // RULE3
        disable iff (!RST_N)
        wr_en && idx == IDX_PHASE_CFG_B |=> cfg_b_q == $past(PWDATA[7:0]))
        else $error("coarse enable write lost");
    a_mask_write: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        wr_en && idx == IDX_IRQ_MASK |=> irq_mask_q == $past(PWDATA[7:0]))
        else $error("mask write lost");
    a_cfg_stable: assert property (@(posedge REF_CLK) // RULE2
        disable iff (!RST_N)
        !wr_en |=> $stable(cfg_a_q) && $stable(cfg_b_q)
        && $stable(freq_cfg_q))
        else $error("enable register changed without a write");

    // interrupt path
    a_change_flag: assert property (@(posedge REF_CLK) // RULE1
        disable iff (!RST_N)
        $changed(lk.locked) |-> lk.lock_changed)
        else $error("lock change not flagged");
    a_stat_set: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        lk.lock_changed |=> irq_stat_q[BIT_LOCK_CHG])
        else $error("lock change not latched");
    a_stat_clear: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        wr_en && idx == IDX_IRQ_STATUS && PWDATA[BIT_LOCK_CHG]
        && !lk.lock_changed |=> !irq_stat_q[BIT_LOCK_CHG])
        else $error("write one did not clear lock change");
    a_irq_raise: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        irq_stat_q[BIT_LOCK_CHG] && irq_mask_q[BIT_LOCK_CHG] |=> IRQ)
        else $error("unmasked lock change without interrupt");
    a_irq_quiet: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        !(irq_stat_q[BIT_LOCK_CHG] && irq_mask_q[BIT_LOCK_CHG]) |=> !IRQ)
        else $error("interrupt without unmasked lock change");

    c_status_read: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        PREADY && PSEL && !PWRITE && idx == IDX_OP_STATUS);
    c_irq_raise: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        !IRQ ##1 IRQ);
    c_unmapped: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        PREADY && PSLVERR);
endmodule

// ---- tb/aux_pll_lock_indicator_tb.sv ----
// self-checking bench for the auxiliary lock indicator and its registers
// assumes the apb slave answers within a few cycles on one clock
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module aux_pll_lock_indicator_tb
    import aux_lock_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [2:0]  flags   = 3'h0;
    logic        coarse  = 1'b0;
    logic [2:0]  mstate  = 3'h1;
    logic        mwarn   = 1'b0;
    logic        awarn   = 1'b0;
    logic [31:0] rdata;
    logic        rerr;
    int          bad_count    = 0;
    int          total_checks = 0;

    aux_lock_top i_dut (
        .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .FINE_PHASE_LOSS(flags[0]),
        .COARSE_PHASE_LOSS(coarse), .INPUT_NO_ACTIVITY(flags[1]),
        .FREQ_LIMIT_HIT(flags[2]), .MAIN_PLL_STATE(mstate),
        .MAIN_PLL_FREQ_WARNING(mwarn), .AUX_PLL_FREQ_WARNING(awarn),
        .IRQ(irq));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            stop_test();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk_lock(input logic exp);
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h024, 8'h00);
        `CHK("lock bit", exp, rdata[BIT_LOCK])
    endtask

    // one loss flag against its enable bit
    task automatic t_det(input int k, input logic [11:0] a,
                         input logic [7:0] off, input logic [7:0] on);
        flags <= 3'h1 << k;
        chk_lock(1'b0);
        apb(1'b1, a, off);
        chk_lock(1'b1);
        apb(1'b1, a, on);
        chk_lock(1'b0);
        flags <= 3'h0;
        chk_lock(1'b1);
    endtask

    task automatic t_coarse();
        coarse <= 1'b1;
        repeat (2) @(posedge clk);
        coarse <= 1'b0;
        chk_lock(1'b0);
        apb(1'b1, 12'h128, 8'h00);
        chk_lock(1'b1);
        coarse <= 1'b1;
        chk_lock(1'b1);
        coarse <= 1'b0;
        apb(1'b1, 12'h128, 8'h80);
        chk_lock(1'b1);
    endtask

    task automatic t_irq();
        apb(1'b1, 12'h020, 8'h40);
        apb(1'b1, 12'h130, 8'h40);
        `CHK("irq idle", 1'b0, irq)
        flags[0] <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b0, 12'h020, 8'h00);
        `CHK("irq status", 32'h40, rdata)
        apb(1'b1, 12'h020, 8'h40);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, 12'h130, 8'h00);
        flags[0] <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b0, 12'h020, 8'h00);
        `CHK("masked status", 32'h40, rdata)
        apb(1'b1, 12'h020, 8'h40);
    endtask

    task automatic t_regs();
        `CHK("ready idle", 1'b0, pready)
        `CHK("irq reset", 1'b0, irq)
        apb(1'b0, 12'h124, 8'h00);
        `CHK("cfg a reset", RST_CFG_A, rdata[7:0])
        apb(1'b0, 12'h128, 8'h00);
        `CHK("cfg b reset", RST_CFG_B, rdata[7:0])
        apb(1'b0, 12'h12C, 8'h00);
        `CHK("freq reset", RST_FREQ_CFG, rdata[7:0])
        apb(1'b0, 12'h130, 8'h00);
        `CHK("mask reset", RST_IRQ_MASK, rdata[7:0])
        apb(1'b1, 12'h024, 8'h00);
        apb(1'b0, 12'h024, 8'h00);
        `CHK("op status", 32'h41, rdata)
        `CHK("mapped err", 1'b0, rerr)
        mstate <= 3'h6;
        mwarn  <= 1'b1;
        apb(1'b0, 12'h024, 8'h00);
        `CHK("op status main", 32'h66, rdata)
        mstate <= 3'h3;
        mwarn  <= 1'b0;
        awarn  <= 1'b1;
        apb(1'b0, 12'h024, 8'h00);
        `CHK("op status aux", 32'h53, rdata)
        mstate <= 3'h1;
        awarn  <= 1'b0;
        apb(1'b0, 12'hC24, 8'h00);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdata)
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_det(0, 12'h124, 8'h40, 8'hC0);
        t_det(1, 12'h124, 8'h80, 8'hC0);
        t_det(2, 12'h12C, 8'h00, 8'h80);
        t_coarse();
        t_irq();
        stop_test();
    end
endmodule
